// >>> hw/rtcdec_core.v
// Real-time control stream decoder of the video encoder: deserialises
// the stream frame, selects received or internal subcarrier increment,
// line sequence, field rate and odd/even flag, and gates the received phase reset.
// Assumes stream and line clock arrive as asynchronous pins; internal
// odd/even and line sequence come from timing logic on clk.
//
// Local design decisions: the placing of the registers and the plain strobed port.
`timescale 1ns/1ns
`include "rtcdec_regs.vh"

module rtcdec_core (
  input  wire                      clk,
  input  wire                      rst_b,
  input  wire                      line_clk_pin,
  input  wire                      realtime_control_stream_in,
  input  wire                      int_odd_even,
  input  wire                      int_line_seq,
  input  wire [`RTCDEC_ADDR_W-1:0] reg_addr,
  input  wire [31:0]               reg_wdata,
  input  wire                      reg_wr,
  input  wire                      reg_rd,
  output reg  [31:0]               reg_rdata,
  output reg  [`RTCDEC_INC_W-1:0]  subcarrier_increment,
  output reg                       use_external_fsc,
  output reg                       line_inverted,
  output reg                       phase_reset_pulse,
  output reg                       field_rate_60,
  output reg                       odd_even,
  output reg                       frame_done
);

  // ****************************************************************
  // Local states and functions
  // ****************************************************************
  localparam [1:0] ST_IDLE = 2'b00;
  localparam [1:0] ST_BODY = 2'b01;
  localparam [1:0] ST_TAIL = 2'b10;

  // Picks the received value when its decode path is enabled
  function pick;
    input enabled;
    input received;
    input internal;
    begin
      pick = enabled ? received : internal;
    end
  endfunction

  // Aligns the received slot according to the source's increment width
  function [`RTCDEC_INC_W-1:0] align_inc;
    input [1:0]               fmt;
    input [`RTCDEC_INC_W-1:0] slot;
    begin
      case (fmt)
        `RTCDEC_FMT_15BIT: align_inc = {9'h000, slot[14:0]};
        `RTCDEC_FMT_22BIT: align_inc = {2'h0, slot[23:2]};
        default:           align_inc = slot;
      endcase
    end
  endfunction

  // ****************************************************************
  // Pin synchronisation and line clock edge
  // ****************************************************************
  wire [1:0] pins_sync;
  reg        lclk_d_reg;
  wire       bit_en;
  wire       rx_bit;

  rtcdec_sync #(
    .W (2)
  ) u_sync (
    .clk      (clk),
    .rst_b    (rst_b),
    .pin_in   ({line_clk_pin, realtime_control_stream_in}),
    .sync_out (pins_sync)
  );

  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      lclk_d_reg <= 1'b0;
    end else begin
      lclk_d_reg <= pins_sync[1];
    end
  end

  // Stream bits are taken on rising edges of the line clock
  assign bit_en = pins_sync[1] & ~lclk_d_reg;
  assign rx_bit = pins_sync[0];

  // ****************************************************************
  // Register file
  // ****************************************************************
  reg  [`RTCDEC_CTRL_W-1:0] ctrl_reg;
  reg  [`RTCDEC_INC_W-1:0]  int_inc_reg;
  wire                      master_en  = ctrl_reg[`RTCDEC_CTRL_MASTER];
  wire                      dec_phase  = ctrl_reg[`RTCDEC_CTRL_DECPHASE];
  wire [1:0]                ph_mode    = ctrl_reg[`RTCDEC_CTRL_PHMODE_HI:`RTCDEC_CTRL_PHMODE_LO];
  wire                      dec_field  = ctrl_reg[`RTCDEC_CTRL_DECFIELD];
  wire                      dec_oe     = ctrl_reg[`RTCDEC_CTRL_ODD_EVEN_DECODE_ENABLE];
  wire                      dec_colour = ctrl_reg[`RTCDEC_CTRL_COLOUR_DETECT_DECODE_ENABLE];
  wire                      field_sel  = ctrl_reg[`RTCDEC_CTRL_FIELDSEL];
  wire [1:0]                inc_fmt    = ctrl_reg[`RTCDEC_CTRL_FMT_HI:`RTCDEC_CTRL_FMT_LO];

  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      ctrl_reg    <= `RTCDEC_CTRL_RESET;
      int_inc_reg <= `RTCDEC_INT_INC_RESET;
    end else if (reg_wr) begin
      case (reg_addr)
        `RTCDEC_OFS_CTRL:    ctrl_reg    <= reg_wdata[`RTCDEC_CTRL_W-1:0];
        `RTCDEC_OFS_INT_INC: int_inc_reg <= reg_wdata[`RTCDEC_INC_W-1:0];
        default: ;
      endcase
    end
  end

  // ****************************************************************
  // Frame receiver
  // ****************************************************************
  reg [1:0]                state_reg;
  reg [1:0]                state_next;
  reg [`RTCDEC_POS_W-1:0]  pos_reg;
  reg [`RTCDEC_POS_W-1:0]  pos_next;
  reg [`RTCDEC_POS_W-1:0]  tail_len_reg;
  reg [`RTCDEC_INC_W-1:0]  slot_reg;
  reg [`RTCDEC_INC_W-1:0]  rx_inc_reg;
  reg                      seq_reg;
  reg                      rst_bit_reg;
  reg                      field_bit_reg;
  reg                      oe_bit_reg;
  reg                      colour_reg;
  reg                      frame_end;
  reg [7:0]                frame_cnt_reg;

  always @* begin
    state_next = state_reg;
    pos_next   = pos_reg;
    frame_end  = 1'b0;
    if (bit_en) begin
      case (state_reg)
        ST_IDLE: begin
          if (rx_bit) begin
            state_next = ST_BODY;
            pos_next   = `RTCDEC_POS_HINC_FIRST;
          end
        end
        ST_BODY: begin
          if (pos_reg == `RTCDEC_POS_COLOUR) begin
            frame_end  = 1'b1;
            state_next = ST_TAIL;
            pos_next   = {`RTCDEC_POS_W{1'b0}};
          end else begin
            pos_next = pos_reg + 9'h001;
          end
        end
        ST_TAIL: begin
          // Reserved tail; its length follows the field bit just received
          if (pos_reg == tail_len_reg - 9'h001) begin
            state_next = ST_IDLE;
            pos_next   = {`RTCDEC_POS_W{1'b0}};
          end else begin
            pos_next = pos_reg + 9'h001;
          end
        end
        default: begin
          state_next = ST_IDLE;
          pos_next   = {`RTCDEC_POS_W{1'b0}};
        end
      endcase
    end
  end

  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      state_reg     <= ST_IDLE;
      pos_reg       <= {`RTCDEC_POS_W{1'b0}};
      tail_len_reg  <= `RTCDEC_TAIL_50HZ;
      slot_reg      <= {`RTCDEC_INC_W{1'b0}};
      rx_inc_reg    <= {`RTCDEC_INC_W{1'b0}};
      seq_reg       <= 1'b0;
      rst_bit_reg   <= 1'b0;
      field_bit_reg <= 1'b0;
      oe_bit_reg    <= 1'b0;
      colour_reg    <= 1'b0;
      frame_cnt_reg <= 8'h00;
    end else begin
      state_reg <= state_next;
      pos_reg   <= pos_next;
      if (bit_en && state_reg == ST_BODY) begin
        // Horizontal increment positions fall through unused
        if (pos_reg >= `RTCDEC_POS_FSC_FIRST && pos_reg <= `RTCDEC_POS_FSC_LAST) begin
          slot_reg <= {slot_reg[`RTCDEC_INC_W-2:0], rx_bit};
        end
        if (pos_reg == `RTCDEC_POS_SEQ) begin
          seq_reg <= rx_bit;
        end
        if (pos_reg == `RTCDEC_POS_RESET) begin
          rst_bit_reg <= rx_bit;
        end
        if (pos_reg == `RTCDEC_POS_FIELD) begin
          field_bit_reg <= rx_bit;
          tail_len_reg  <= rx_bit ? `RTCDEC_TAIL_60HZ : `RTCDEC_TAIL_50HZ;
        end
        if (pos_reg == `RTCDEC_POS_ODDEVEN) begin
          oe_bit_reg <= rx_bit;
        end
        if (pos_reg == `RTCDEC_POS_COLOUR) begin
          colour_reg <= rx_bit;
        end
      end
      if (frame_end) begin
        rx_inc_reg    <= align_inc(inc_fmt, slot_reg);
        frame_cnt_reg <= frame_cnt_reg + 8'h01;
      end
    end
  end

  // ****************************************************************
  // Selection of received or internal values
  // ****************************************************************
  wire ext_fsc_sel;
  wire field_60_sel;
  wire oe_sel;
  wire seq_sel;
  wire phase_hit;

  // Colour decode off: received increment regardless of colour bit
  assign ext_fsc_sel  = master_en & (~dec_colour | colour_reg);
  assign field_60_sel = pick(master_en & dec_field, field_bit_reg, field_sel);
  assign oe_sel       = pick(master_en & dec_oe, oe_bit_reg, int_odd_even);
  // NTSC: sequence bit carries no inversion
  assign seq_sel      = pick(master_en, seq_reg & ~field_60_sel, int_line_seq);
  assign phase_hit    = frame_end & master_en & dec_phase &
                        (ph_mode == `RTCDEC_PHMODE_LINE);

  // ****************************************************************
  // Outputs, all registered
  // ****************************************************************
  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      subcarrier_increment <= `RTCDEC_INT_INC_RESET;
      use_external_fsc     <= 1'b0;
      line_inverted        <= 1'b0;
      phase_reset_pulse    <= 1'b0;
      field_rate_60        <= 1'b0;
      odd_even             <= 1'b0;
      frame_done           <= 1'b0;
    end else begin
      subcarrier_increment <= ext_fsc_sel ? rx_inc_reg : int_inc_reg;
      use_external_fsc     <= ext_fsc_sel;
      line_inverted        <= seq_sel;
      // Reset bit is judged at frame end so the line sees one pulse
      phase_reset_pulse    <= phase_hit & rst_bit_reg;
      field_rate_60        <= field_60_sel;
      odd_even             <= oe_sel;
      frame_done           <= frame_end;
    end
  end

  // ****************************************************************
  // Register read-back, data valid the cycle after the strobe
  // ****************************************************************
  reg [31:0] rdata_next;

  always @* begin
    rdata_next = 32'h00000000;
    case (reg_addr)
      `RTCDEC_OFS_CTRL:    rdata_next[`RTCDEC_CTRL_W-1:0] = ctrl_reg;
      `RTCDEC_OFS_INT_INC: rdata_next[`RTCDEC_INC_W-1:0]  = int_inc_reg;
      `RTCDEC_OFS_RX_INC:  rdata_next[`RTCDEC_INC_W-1:0]  = rx_inc_reg;
      `RTCDEC_OFS_STATUS: begin
        rdata_next[`RTCDEC_ST_SEQ]     = seq_reg;
        rdata_next[`RTCDEC_ST_RESET]   = rst_bit_reg;
        rdata_next[`RTCDEC_ST_FIELD]   = field_bit_reg;
        rdata_next[`RTCDEC_ST_ODDEVEN] = oe_bit_reg;
        rdata_next[`RTCDEC_ST_COLOUR]  = colour_reg;
        rdata_next[`RTCDEC_ST_EXTFSC]  = use_external_fsc;
        rdata_next[`RTCDEC_ST_BUSY]    = (state_reg != ST_IDLE);
        rdata_next[`RTCDEC_ST_COUNT_LO+7:`RTCDEC_ST_COUNT_LO] = frame_cnt_reg;
      end
      default: rdata_next = 32'h00000000;
    endcase
  end

  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      reg_rdata <= 32'h00000000;
    end else if (reg_rd) begin
      reg_rdata <= rdata_next;
    end else begin
      reg_rdata <= 32'h00000000;
    end
  end

endmodule // rtcdec_core

// >>> common/rtcdec_regs.vh
// Constants of the real-time control stream decoder: register map,
// field layout of a stream frame, reset values and frame lengths.
// Assumes inclusion by bare name from the design files.
`ifndef RTCDEC_REGS_VH
`define RTCDEC_REGS_VH

// ****************************************************************
// Register offsets (byte addresses)
// ****************************************************************
`define RTCDEC_ADDR_W          8
`define RTCDEC_OFS_CTRL        8'h00
`define RTCDEC_OFS_INT_INC     8'h04
`define RTCDEC_OFS_RX_INC      8'h08
`define RTCDEC_OFS_STATUS      8'h0C

// ****************************************************************
// Control register fields
// ****************************************************************
`define RTCDEC_CTRL_MASTER     0
`define RTCDEC_CTRL_DECPHASE   1
`define RTCDEC_CTRL_PHMODE_LO  2
`define RTCDEC_CTRL_PHMODE_HI  3
`define RTCDEC_CTRL_DECFIELD   4
`define RTCDEC_CTRL_ODD_EVEN_DECODE_ENABLE      5
`define RTCDEC_CTRL_COLOUR_DETECT_DECODE_ENABLE     6
`define RTCDEC_CTRL_FIELDSEL   7
`define RTCDEC_CTRL_FMT_LO     8
`define RTCDEC_CTRL_FMT_HI     9
`define RTCDEC_CTRL_W          10
`define RTCDEC_CTRL_RESET      10'h000
`define RTCDEC_PHMODE_LINE     2'h0

// Increment formats supplied by the far end
`define RTCDEC_FMT_FULL        2'h0
`define RTCDEC_FMT_15BIT       2'h1
`define RTCDEC_FMT_22BIT       2'h2

// ****************************************************************
// Status register fields
// ****************************************************************
`define RTCDEC_ST_SEQ          0
`define RTCDEC_ST_RESET        1
`define RTCDEC_ST_FIELD        2
`define RTCDEC_ST_ODDEVEN      3
`define RTCDEC_ST_COLOUR       4
`define RTCDEC_ST_EXTFSC       5
`define RTCDEC_ST_BUSY         6
`define RTCDEC_ST_COUNT_LO     8

// ****************************************************************
// Subcarrier increment
// ****************************************************************
`define RTCDEC_INC_W           24
`define RTCDEC_INT_INC_RESET   24'h000000

// ****************************************************************
// Frame layout: bit positions counted from the start bit (position 0)
// ****************************************************************
`define RTCDEC_POS_W           9
`define RTCDEC_POS_HINC_FIRST  9'h001
`define RTCDEC_POS_HINC_LAST   9'h016
`define RTCDEC_POS_FSC_FIRST   9'h019
`define RTCDEC_POS_FSC_LAST    9'h030
`define RTCDEC_POS_SEQ         9'h034
`define RTCDEC_POS_RESET       9'h035
`define RTCDEC_POS_FIELD       9'h036
`define RTCDEC_POS_ODDEVEN     9'h037
`define RTCDEC_POS_COLOUR      9'h038
`define RTCDEC_TAIL_50HZ       9'h0E5
`define RTCDEC_TAIL_60HZ       9'h0E2

`endif

// >>> hw/rtcdec_sync.v
// Two-flop synchroniser for a group of single-bit pins.
// Assumes each bit is a level that changes no faster than the clock
// can follow; no relation between bits is preserved.
`timescale 1ns/1ns

module rtcdec_sync #(
  parameter W = 2
) (
  input  wire         clk,
  input  wire         rst_b,
  input  wire [W-1:0] pin_in,
  output wire [W-1:0] sync_out
);

  reg [W-1:0] meta_reg;
  reg [W-1:0] stable_reg;

  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      meta_reg   <= {W{1'b0}};
      stable_reg <= {W{1'b0}};
    end else begin
      meta_reg   <= pin_in;
      stable_reg <= meta_reg;
    end
  end

  assign sync_out = stable_reg;

endmodule // rtcdec_sync

// >>> tb/rtcdec_checker.sv
// Port-level assertions for the real-time control stream decoder.
// Assumes bind onto rtcdec_core and no register writes near a frame end.
`timescale 1ns/1ns
`include "rtcdec_regs.vh"

module rtcdec_checker (
  input logic                      clk,
  input logic                      rst_b,
  input logic                      line_clk_pin,
  input logic                      int_odd_even,
  input logic                      int_line_seq,
  input logic [`RTCDEC_ADDR_W-1:0] reg_addr,
  input logic [31:0]               reg_wdata,
  input logic                      reg_wr,
  input logic [`RTCDEC_INC_W-1:0]  subcarrier_increment,
  input logic                      use_external_fsc,
  input logic                      line_inverted,
  input logic                      phase_reset_pulse,
  input logic                      field_rate_60,
  input logic                      odd_even,
  input logic                      frame_done
);
  // ****************************************
  // Helper state
  // ****************************************
  logic [9:0] ctrl_q, edge_cnt;
  logic       lc_q, seen_q, wr_d1, wr_d2, fd_d1, fd_d2, up_d1;
  // Any legal reason for a selected output to move
  wire        cause = wr_d1 | wr_d2 | fd_d1 | fd_d2 | !up_d1;

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      {ctrl_q, edge_cnt, lc_q, seen_q, wr_d1, wr_d2, fd_d1, fd_d2, up_d1} <= '0;
    end else begin
      {lc_q, wr_d1, wr_d2, up_d1} <= {line_clk_pin, reg_wr, wr_d1, 1'b1};
      {fd_d1, fd_d2} <= {frame_done, fd_d1};
      if (reg_wr && reg_addr == `RTCDEC_OFS_CTRL) begin
        ctrl_q <= reg_wdata[9:0];
      end
      // Saturates so an idle gap cannot wrap into a short count
      if (frame_done) begin
        edge_cnt <= 10'h000;
        seen_q <= 1'b1;
      end else if (line_clk_pin && !lc_q && edge_cnt != 10'h3FF) begin
        edge_cnt <= edge_cnt + 10'h001;
      end
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);

  pulse_gate_a:
    assert property (phase_reset_pulse |-> frame_done && ctrl_q[1:0] == 2'h3 &&
      ctrl_q[3:2] == `RTCDEC_PHMODE_LINE) else $error("phase reset without enables");
  frame_gap_a:
    assert property (frame_done && seen_q |-> edge_cnt >= 10'h11A)
      else $error("frames closer than body plus tail");
  ext_cause_a:
    assert property ($changed(use_external_fsc) |-> cause) else $error("fsc source moved");
  inc_cause_a:
    assert property ($changed(subcarrier_increment) |-> cause) else $error("increment moved");
  field_cause_a:
    assert property ($changed(field_rate_60) |-> cause or ##[0:40] frame_done)
      else $error("field rate moved");
  oe_cause_a:
    assert property ($changed(odd_even) |->
      (cause || $past(int_odd_even) != $past(int_odd_even, 2)) or ##[0:40] frame_done)
      else $error("odd even moved without cause");
  seq_cause_a:
    assert property ($changed(line_inverted) |->
      (cause || $past(int_line_seq) != $past(int_line_seq, 2)) or ##[0:40] frame_done)
      else $error("line inversion moved without cause");
  master_off_a:
    assert property (!ctrl_q[0] && !$past(ctrl_q[0]) |-> !use_external_fsc && !phase_reset_pulse)
      else $error("received values used with master off");
  direct_inc_a:
    assert property (frame_done && ctrl_q[0] && !ctrl_q[6] |=> use_external_fsc)
      else $error("received increment not used");

  cover property (phase_reset_pulse);
  cover property (frame_done && field_rate_60);
  cover property ($rose(use_external_fsc));
endmodule // rtcdec_checker

bind rtcdec_core rtcdec_checker rtcdec_checker_inst (.clk(clk), .rst_b(rst_b),
  .line_clk_pin(line_clk_pin), .int_odd_even(int_odd_even), .int_line_seq(int_line_seq),
  .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
  .subcarrier_increment(subcarrier_increment), .use_external_fsc(use_external_fsc),
  .line_inverted(line_inverted), .phase_reset_pulse(phase_reset_pulse),
  .field_rate_60(field_rate_60), .odd_even(odd_even), .frame_done(frame_done));

// >>> tb/rtcdec_src_model.sv
// Far-end decoder model: free-running line clock and serial control frames.
// Assumes the bench calls send_frame; the stream idles low between frames.
`timescale 1ns/1ns

module rtcdec_src_model (
  output logic line_clk_pin,
  output logic realtime_control_stream_in
);
  initial begin
    line_clk_pin = 1'b0;
    realtime_control_stream_in = 1'b0;
    #1;
    forever #18 line_clk_pin = ~line_clk_pin;
  end

  // Data moves on the falling edge, clear of the sampling edge
  task automatic send_frame(input logic [23:0] slot, input logic sq, rb, fb, ob, col);
    logic [56:0] body;
    int          tail;
    body = {1'b1, 22'($urandom), 2'($urandom), slot, 3'($urandom), sq, rb, fb, ob, col};
    tail = fb ? 226 : 229;
    for (int p = 0; p < 59 + tail; p++) begin
      @(negedge line_clk_pin);
      realtime_control_stream_in <= p < 57 ? body[56 - p] : (p < 57 + tail) & 1'($urandom);
    end
  endtask
endmodule // rtcdec_src_model

// >>> tb/realtime_control_input_decoder_tb.sv
// Self-checking bench for rtcdec_core with a far-end stream model.
// Assumes a 250 MHz clock and a 36 ns line clock from the model.
`timescale 1ns/1ns
`include "rtcdec_regs.vh"

module realtime_control_input_decoder_tb;
  logic        clk, rst_b, int_odd_even, int_line_seq, reg_wr, reg_rd;
  logic        use_external_fsc, line_inverted, phase_reset_pulse, field_rate_60;
  logic        odd_even, frame_done, line_clk_pin, realtime_control_stream_in;
  logic [7:0]  reg_addr;
  logic [31:0] reg_wdata, reg_rdata;
  logic [23:0] subcarrier_increment;
  int          n_mismatch, samples_checked;
  int          exp_q[$];
  logic [9:0]  ctrl_tab [8] = '{10'h000, 10'h080, 10'h073, 10'h033, 10'h077, 10'h173,
                                10'h273, 10'h0A1};

  rtcdec_core rtcdec_core_inst (.clk, .rst_b, .line_clk_pin, .realtime_control_stream_in,
    .int_odd_even, .int_line_seq, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
    .subcarrier_increment, .use_external_fsc, .line_inverted, .phase_reset_pulse,
    .field_rate_60, .odd_even, .frame_done);
  rtcdec_src_model rtcdec_src_model_inst (.line_clk_pin, .realtime_control_stream_in);

  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end

  // ****************************************
  // Checking and bus tasks
  // ****************************************
  task automatic chk(input logic [31:0] seen, input logic [31:0] expd);
    samples_checked++;
    if (seen !== expd) begin
      n_mismatch++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, expd);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] expd);
    @(posedge clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1 chk(reg_rdata, expd);
  endtask

  task automatic report_and_stop;
    $display("comparisons %0d mismatches %0d", samples_checked, n_mismatch);
    if (n_mismatch == 0 && samples_checked > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  // Sixteen frames of about 2.6k cycles each, with generous margin
  initial begin
    #250000;
    n_mismatch++;
    report_and_stop();
  end

  initial begin
    logic [23:0] slot, ii, irx;
    logic [9:0]  c;
    logic        sq, rb, fb, ob, col, ioe, ils, m, x_ext, x_f60, seen;
    void'($urandom(63));
    {rst_b, int_odd_even, int_line_seq, reg_wr, reg_rd} = 5'h00;
    reg_addr = 8'h00;
    reg_wdata = 32'h00000000;
    repeat (8) @(posedge clk);
    rst_b <= 1'b1;
    rd(`RTCDEC_OFS_CTRL, 32'h00000000);
    rd(`RTCDEC_OFS_INT_INC, 32'h00000000);
    rd(8'h40, 32'h00000000);
    wr(`RTCDEC_OFS_STATUS, 32'hFFFFFFFF);
    for (int i = 0; i < 16; i++) begin
      c = ctrl_tab[i % 8];
      {ii, slot, sq, fb, ob, ioe, ils} = 53'({$urandom, $urandom});
      col = i[3];
      rb = col | 1'($urandom);
      wr(`RTCDEC_OFS_CTRL, {22'h000000, c});
      wr(`RTCDEC_OFS_INT_INC, {8'h00, ii});
      rd(`RTCDEC_OFS_CTRL, {22'h000000, c});
      @(posedge clk);
      int_odd_even <= ioe;
      int_line_seq <= ils;
      m = c[0];
      irx = c[9:8] == `RTCDEC_FMT_15BIT ? {9'h000, slot[14:0]} :
            c[9:8] == `RTCDEC_FMT_22BIT ? {2'h0, slot[23:2]} : slot;
      x_ext = m && (!c[6] || col);
      x_f60 = (m && c[4]) ? fb : c[7];
      exp_q.push_back(int'(m && c[1] && c[3:2] == 2'h0 && rb));
      fork
        rtcdec_src_model_inst.send_frame(slot, sq, rb, fb, ob, col);
        begin
          seen = 1'b0;
          for (int t = 0; t < 4000 && !seen; t++) begin
            @(posedge clk);
            #1 seen = frame_done === 1'b1;
          end
          chk(seen, 1'b1);
          chk(phase_reset_pulse, exp_q.pop_front());
          repeat (2) @(posedge clk);
          #1 chk(subcarrier_increment, x_ext ? irx : ii);
          chk(use_external_fsc, x_ext);
          chk(field_rate_60, x_f60);
          chk(odd_even, (m && c[5]) ? ob : ioe);
          chk(line_inverted, m ? (!x_f60 && sq) : ils);
          // Receiver is still inside the reserved tail here, so busy reads 1
          rd(`RTCDEC_OFS_STATUS, {16'h0000, 8'(i + 1), 2'h1, x_ext, col, ob, fb, rb, sq});
          rd(`RTCDEC_OFS_RX_INC, {8'h00, irx});
        end
      join
    end
    report_and_stop();
  end
endmodule // realtime_control_input_decoder_tb
